// ==== logic/sbc_mode_pkg.sv ====
// shared types, encodings and timing constants of the operating-mode controller
package sbc_mode_pkg;

  typedef enum logic [2:0] {
    mode_reset,
    mode_normal_request,
    mode_normal,
    mode_stop,
    mode_sleep
  } op_mode_type;

  // interrupt source register layout; the three wake bits sit on top
  typedef struct packed {
    logic wake_input;
    logic bus_wake;
    logic timer_wake;
    logic supply_under;
    logic supply_over;
    logic thermal_warn;
  } irq_src_type;

  typedef struct packed {
    logic mode_select_bit_high;
    logic mode_select_bit_low;
  } mode_select_type;

  localparam logic [1:0] MODE_SEL_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SEL_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_SEL_STOP   = 2'h2;

  localparam irq_src_type IRQ_SRC_RESET  = 6'h00;
  localparam irq_src_type WAKE_SRC_MASK  = 6'h38;
  localparam logic        BATT_FAIL_RESET = 1'b1;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int RESET_HOLD_US   = 1000;
  localparam int NREQ_TIMEOUT_MS = 150;
  localparam int VDD_LOW_MS      = 150;
  localparam int LP_PERIOD_MS    = 20;

  // least time, rounded up
  localparam int RESET_HOLD_CYCLES =
    (RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest times, rounded down
  localparam int NREQ_TIMEOUT_CYCLES = NREQ_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int VDD_LOW_CYCLES      = VDD_LOW_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LP_PERIOD_CYCLES    = LP_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

endpackage : sbc_mode_pkg

// ==== logic/sbc_tick_counter.sv ====
// free-running interval counter with a one-cycle expiry pulse
`timescale 1ns/1ps
module sbc_tick_counter #(
  parameter int COUNT = 16
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      expired
);

  localparam int              W    = $clog2(COUNT + 1);
  localparam logic [W-1:0]    LAST = W'(COUNT - 1);

  logic [W-1:0] count;
  wire          at_last = (count == LAST);
  wire  [W-1:0] next_count = (!run || at_last) ? '0 : count + 1'b1;

  // pulse comes COUNT cycles after run rises, then repeats while run holds
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= run && at_last;
    end
  end

  expiry_on_last_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    run && at_last |=> expired) else $error("interval did not expire");
  no_early_expiry_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !run |=> !expired) else $error("expiry without run");

endmodule : sbc_tick_counter

// ==== logic/sbc_wake_detect.sv ====
// state-change wake detector for the two wake inputs, direct or cyclic
`timescale 1ns/1ps
module sbc_wake_detect (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic armed,
  input  wire logic cyclic_enable,
  input  wire logic sample,
  input  wire logic wake_input_one,
  input  wire logic wake_input_two,
  output logic      wake
);

  logic [1:0] ref_level;
  wire  [1:0] level   = {wake_input_two, wake_input_one};
  wire        changed = (level != ref_level);
  // in cyclic sensing the inputs only count while the high side is on
  wire        check   = armed && (cyclic_enable ? sample : 1'b1);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_level <= 2'h0;
      wake      <= 1'b0;
    end else begin
      wake <= check && changed;
      if (!armed || check) begin
        ref_level <= level;
      end
    end
  end

  cyclic_gap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    armed && cyclic_enable && !sample |=> !wake) else $error("wake between samples");

endmodule : sbc_wake_detect

// ==== logic/sbc_operating_mode_controller.sv ====
// operating-mode state machine, reset line and interrupt line of the basis chip
//
// What this block does
// - after power-up sit in Reset, hold reset line low 1.0 ms, then Normal Request
// - enter Reset on regulator low, watchdog failure, sleep wake or request timeout
// - Normal Request follows Reset and Stop wake-up; it is only a passing mode
// - Normal Request: regulator on, reset line high, bus receive only
// - Normal Request starts a 150 ms timer; no Normal command in time means Reset
// - watchdog pin grounded: Reset goes straight to Normal, skipping Normal Request
// - mode chosen by the two mode-select bits the host writes
// - Normal to Sleep on sleep command, or regulator low over 150 ms without undervoltage
// - in Reset, regulator low without supply undervoltage goes to Sleep
// - Sleep: regulator off, only wake inputs, forced timer and bus wake stay alive
// - cyclic sensing pulses high side each period and samples wake inputs then
// - sleep wake goes through Reset, records source, leaves battery fail clear
// - Stop only on stop command; regulator stays on, current limited
// - Stop wakes on inputs, bus, timer, select rise, reset line; Sleep on first three
// - Stop wake goes to Normal Request with interrupt, none for select or reset line; reset line goes to Normal instead when watchdog pin grounded
// - switches follow settings, optionally gated by pulse input, in active modes only
// - no new interrupt while wake sources remain unread, except in Stop
// - interrupt line held low until the source register is read, then high
// - interrupts only in Normal, Normal Request, Stop; never with reset line low
// - masked sources never pull the interrupt line low
// - active modes interrupt on supply under, over voltage and thermal prewarning
// - reset line low while a reset cause lasts and 1.0 ms after it clears
`timescale 1ns/1ps
module sbc_operating_mode_controller
  import sbc_mode_pkg::*;
#(
  parameter int RESET_HOLD   = RESET_HOLD_CYCLES,
  parameter int NREQ_TIMEOUT = NREQ_TIMEOUT_CYCLES,
  parameter int VDD_LOW_TIME = VDD_LOW_CYCLES,
  parameter int LP_PERIOD    = LP_PERIOD_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    vdd_low,
  input  wire logic                    watchdog_fail,
  input  wire logic                    supply_undervoltage_flag,
  input  wire logic                    supply_overvoltage_flag,
  input  wire logic                    thermal_prewarning,
  input  wire logic                    watchdog_config_pin_grounded,
  input  wire logic                    reset_line_in,
  input  wire logic                    mode_write,
  input  wire sbc_mode_pkg::mode_select_type mode_control_register,
  input  wire logic                    isr_read,
  input  wire sbc_mode_pkg::irq_src_type interrupt_mask_register,
  input  wire logic                    chip_select_n,
  input  wire logic                    wake_input_one,
  input  wire logic                    wake_input_two,
  input  wire logic                    bus_wake,
  input  wire logic                    cyclic_sense_enable,
  input  wire logic                    forced_wake_enable,
  input  wire logic [1:0]              low_side_setting,
  input  wire logic                    high_side_setting,
  input  wire logic                    pwm_gate_enable,
  input  wire logic                    pulse_width_input,
  output sbc_mode_pkg::op_mode_type    operating_mode,
  output sbc_mode_pkg::irq_src_type    interrupt_source,
  output logic                         reset_line_out,
  output logic                         reset_line_oe_n,
  output logic                         irq_n,
  output logic                         battery_fail_flag,
  output logic                         regulator_on,
  output logic                         regulator_limited,
  output logic                         bus_rx_only,
  output logic                         bus_tx_enable,
  output logic [1:0]                   low_side_outputs,
  output logic                         high_side_output
);

  import sbc_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  op_mode_type next_mode;
  logic        cs_prev;
  logic        uv_prev;
  logic        ov_prev;
  logic        tw_prev;
  logic        irq_active;
  logic        hold_done;
  logic        nreq_expired;
  logic        vdd_low_expired;
  logic        period_tick;
  logic        input_wake;

  // the line reads low while we pull it, so only a released line can show an external reset
  wire ext_reset   = reset_line_oe_n && !reset_line_in;
  wire reset_cause = vdd_low || ext_reset;
  wire [1:0] mode_sel = mode_control_register;
  wire cmd_normal  = mode_write && (mode_sel == MODE_SEL_NORMAL);
  wire cmd_sleep   = mode_write && (mode_sel == MODE_SEL_SLEEP);
  wire cmd_stop    = mode_write && (mode_sel == MODE_SEL_STOP);
  wire in_reset    = (operating_mode == mode_reset);
  wire in_nreq     = (operating_mode == mode_normal_request);
  wire in_normal   = (operating_mode == mode_normal);
  wire in_stop     = (operating_mode == mode_stop);
  wire in_sleep    = (operating_mode == mode_sleep);
  wire low_power   = in_stop || in_sleep;
  wire active_mode = in_nreq || in_normal;
  wire cs_rise     = in_stop && !cs_prev && chip_select_n;
  // forced wake gives way to cyclic sensing, the two are exclusive
  wire timer_wake  = period_tick && forced_wake_enable && !cyclic_sense_enable;
  wire src_wake    = input_wake || bus_wake || timer_wake;
  wire sense_on    = low_power && cyclic_sense_enable;
  wire op_mode_type after_reset =
    watchdog_config_pin_grounded ? mode_normal : mode_normal_request;

  ////////////////////////////////////////////////////////////////////////////
  // timers
  sbc_tick_counter #(.COUNT(RESET_HOLD)) hold_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (in_reset && !reset_cause),
    .expired  (hold_done)
  );

  sbc_tick_counter #(.COUNT(NREQ_TIMEOUT)) nreq_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (in_nreq),
    .expired  (nreq_expired)
  );

  sbc_tick_counter #(.COUNT(VDD_LOW_TIME)) vdd_low_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (in_normal && vdd_low && !supply_undervoltage_flag),
    .expired  (vdd_low_expired)
  );

  sbc_tick_counter #(.COUNT(LP_PERIOD)) period_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .run      (low_power && (cyclic_sense_enable || forced_wake_enable)),
    .expired  (period_tick)
  );

  // the sample lands in the cycle the high side is already on
  sbc_wake_detect wake_detect (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .armed          (low_power),
    .cyclic_enable  (cyclic_sense_enable),
    .sample         (sense_on && high_side_output),
    .wake_input_one (wake_input_one),
    .wake_input_two (wake_input_two),
    .wake           (input_wake)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine
  always_comb begin
    next_mode = operating_mode;
    case (operating_mode)
      mode_reset: begin
        if (vdd_low && !supply_undervoltage_flag) begin
          next_mode = mode_sleep;
        end else if (hold_done) begin
          next_mode = after_reset;
        end
      end
      mode_normal_request: begin
        if (reset_cause || nreq_expired) begin
          next_mode = mode_reset;
        end else if (cmd_normal) begin
          next_mode = mode_normal;
        end
      end
      mode_normal: begin
        if (vdd_low_expired) begin
          next_mode = mode_sleep;
        end else if ((vdd_low && supply_undervoltage_flag) || watchdog_fail || ext_reset) begin
          next_mode = mode_reset;
        end else if (cmd_sleep) begin
          next_mode = mode_sleep;
        end else if (cmd_stop) begin
          next_mode = mode_stop;
        end
      end
      mode_stop: begin
        if (vdd_low) begin
          next_mode = mode_reset;
        end else if (ext_reset) begin
          next_mode = after_reset;
        end else if (src_wake || cs_rise) begin
          next_mode = mode_normal_request;
        end
      end
      mode_sleep: begin
        if (src_wake) begin
          next_mode = mode_reset;
        end
      end
      default: next_mode = mode_reset;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources and line
  irq_src_type event_src;
  irq_src_type next_source;
  assign event_src = '{
    wake_input:   low_power && input_wake,
    bus_wake:     low_power && bus_wake,
    timer_wake:   low_power && timer_wake,
    supply_under: active_mode && supply_undervoltage_flag && !uv_prev,
    supply_over:  active_mode && supply_overvoltage_flag && !ov_prev,
    thermal_warn: active_mode && thermal_prewarning && !tw_prev};

  // an event in the read cycle survives the clear
  assign next_source = (isr_read ? IRQ_SRC_RESET : interrupt_source) | event_src;

  wire wake_pending = |(interrupt_source & WAKE_SRC_MASK);
  wire irq_allowed  = (next_mode inside {mode_normal_request, mode_normal, mode_stop})
                      && !ext_reset;
  wire irq_fire     = |(event_src & ~interrupt_mask_register)
                      && (in_stop || !wake_pending);
  wire next_irq_active = irq_allowed && (irq_fire || (irq_active && !isr_read));

  ////////////////////////////////////////////////////////////////////////////
  // switches: the pulse input only gates, it never turns a switch on alone
  wire next_active = next_mode inside {mode_normal_request, mode_normal};
  wire pwm_gate    = pwm_gate_enable ? pulse_width_input : 1'b1;
  wire [1:0] next_low_side = next_active ? (low_side_setting & {2{pwm_gate}}) : 2'h0;
  wire next_high_side = next_active ? (high_side_setting && pwm_gate)
                                    : (sense_on && period_tick);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      operating_mode    <= mode_reset;
      interrupt_source  <= IRQ_SRC_RESET;
      battery_fail_flag <= BATT_FAIL_RESET;
      irq_active        <= 1'b0;
      irq_n             <= 1'b1;
      cs_prev           <= 1'b1;
      uv_prev           <= 1'b0;
      ov_prev           <= 1'b0;
      tw_prev           <= 1'b0;
    end else begin
      operating_mode    <= next_mode;
      interrupt_source  <= next_source;
      // only power-up sets it; a sleep wake leaves it clear
      battery_fail_flag <= battery_fail_flag && !isr_read;
      irq_active        <= next_irq_active;
      irq_n             <= !next_irq_active;
      cs_prev           <= chip_select_n;
      uv_prev           <= supply_undervoltage_flag;
      ov_prev           <= supply_overvoltage_flag;
      tw_prev           <= thermal_prewarning;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reset_line_out    <= 1'b0;
      reset_line_oe_n   <= 1'b0;
      regulator_on      <= 1'b1;
      regulator_limited <= 1'b0;
      bus_rx_only       <= 1'b0;
      bus_tx_enable     <= 1'b0;
      low_side_outputs  <= 2'h0;
      high_side_output  <= 1'b0;
    end else begin
      reset_line_out    <= 1'b0;
      reset_line_oe_n   <= (next_mode != mode_reset);
      regulator_on      <= (next_mode != mode_sleep);
      regulator_limited <= (next_mode == mode_stop);
      bus_rx_only       <= next_mode inside {mode_normal_request, mode_stop};
      bus_tx_enable     <= (next_mode == mode_normal);
      low_side_outputs  <= next_low_side;
      high_side_output  <= next_high_side;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  reset_line_low_a: assert property (in_reset |-> !reset_line_oe_n)
    else $error("reset line released in reset mode");

  hold_before_release_a: assert property (
    $past(operating_mode) == mode_reset && operating_mode inside {mode_normal_request,
      mode_normal} |-> $past(hold_done)) else $error("reset left before hold time");

  nreq_timeout_a: assert property (
    in_nreq && nreq_expired |=> in_reset && !reset_line_oe_n)
    else $error("normal request timeout missed");

  skip_nreq_a: assert property (
    in_reset && hold_done && !vdd_low && watchdog_config_pin_grounded |=> in_normal)
    else $error("grounded watchdog pin did not skip normal request");

  reset_to_sleep_a: assert property (
    in_reset && vdd_low && !supply_undervoltage_flag |=> in_sleep && !regulator_on)
    else $error("regulator low in reset did not reach sleep");

  sleep_off_a: assert property (in_sleep |-> !regulator_on && !irq_n == 1'b0)
    else $error("regulator or interrupt alive in sleep");

  irq_modes_a: assert property (
    !irq_n |-> operating_mode inside {mode_normal_request, mode_normal, mode_stop}
      && reset_line_oe_n) else $error("interrupt outside allowed modes");

  irq_hold_a: assert property (
    !irq_n && !isr_read && !ext_reset && next_mode inside {mode_normal_request,
      mode_normal, mode_stop} |=> !irq_n) else $error("interrupt dropped before read");

  quiet_wake_a: assert property (
    in_stop && cs_rise && !src_wake && !vdd_low && !ext_reset && irq_n
      |=> in_nreq && irq_n) else $error("select wake raised an interrupt");

  switches_off_a: assert property (
    in_reset |-> low_side_outputs == 2'h0 && !high_side_output)
    else $error("switch on in reset mode");

  enter_normal_c: cover property (in_nreq && cmd_normal ##1 in_normal);
  stop_wake_c:    cover property (in_stop && input_wake ##1 in_nreq && !irq_n);
  sleep_wake_c:   cover property (in_sleep && src_wake ##1 in_reset);
  irq_ack_c:      cover property (!irq_n && isr_read ##1 irq_n);

endmodule : sbc_operating_mode_controller

// ==== test/host_mcu_model.sv ====
// host microcontroller model: reset line pull-down and interrupt acknowledge
`timescale 1ns/1ps
module host_mcu_model #(
  parameter int ACK_DELAY = 3
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic reset_line_oe_n,
  input  wire logic host_pull_n,
  input  wire logic irq_n,
  input  wire logic auto_ack,
  output logic      reset_line_in,
  output logic      isr_read
);
  int wait_count;

  // open-drain line with a weak pull-up: low when either party pulls it
  assign reset_line_in = reset_line_oe_n & host_pull_n;

  // a slow host: the source register is read some cycles after the line falls
  always_ff @(posedge core_clk) begin
    if (!rst_n || !auto_ack || irq_n) begin
      wait_count <= 0;
      isr_read   <= 1'b0;
    end else if (wait_count == ACK_DELAY) begin
      wait_count <= 0;
      isr_read   <= 1'b1;
    end else begin
      wait_count <= wait_count + 1;
      isr_read   <= 1'b0;
    end
  end
endmodule : host_mcu_model

// ==== test/sbc_operating_mode_controller_test.sv ====
// self-checking bench of the operating-mode controller
`timescale 1ns/1ps
module sbc_operating_mode_controller_test;
  import sbc_mode_pkg::*;
  localparam int HOLD = 8;
  localparam int NREQ = 40;
  localparam int VLOW = 30;
  localparam int LP   = 10;
  logic core_clk, rst_n, vdd_low, watchdog_fail, supply_undervoltage_flag;
  logic supply_overvoltage_flag, watchdog_config_pin_grounded, reset_line_in, mode_write;
  logic isr_read, host_read, bench_read, chip_select_n, wake_input_one, bus_wake, seen;
  logic high_side_setting, pwm_gate_enable, pulse_width_input, host_pull_n, auto_ack;
  logic reset_line_oe_n, irq_n, battery_fail_flag, regulator_on, regulator_limited;
  logic bus_rx_only, bus_tx_enable, high_side_output, reset_line_out, thermal_prewarning;
  logic wake_input_two, cyclic_sense_enable, forced_wake_enable;
  logic [1:0] low_side_setting, low_side_outputs;
  mode_select_type mode_control_register;
  irq_src_type interrupt_mask_register, interrupt_source;
  op_mode_type operating_mode;
  int fails, n_compared, n;

  assign isr_read = host_read | bench_read;

  sbc_operating_mode_controller #(.RESET_HOLD(HOLD), .NREQ_TIMEOUT(NREQ),
    .VDD_LOW_TIME(VLOW), .LP_PERIOD(LP)) uut (
    .core_clk, .rst_n, .vdd_low, .watchdog_fail, .supply_undervoltage_flag,
    .supply_overvoltage_flag, .thermal_prewarning, .watchdog_config_pin_grounded,
    .reset_line_in, .mode_write, .mode_control_register, .isr_read, .interrupt_mask_register,
    .chip_select_n, .wake_input_one, .wake_input_two, .bus_wake,
    .cyclic_sense_enable, .forced_wake_enable, .low_side_setting,
    .high_side_setting, .pwm_gate_enable, .pulse_width_input, .operating_mode,
    .interrupt_source, .reset_line_out, .reset_line_oe_n, .irq_n, .battery_fail_flag,
    .regulator_on, .regulator_limited, .bus_rx_only, .bus_tx_enable, .low_side_outputs,
    .high_side_output);

  host_mcu_model host (.core_clk, .rst_n, .reset_line_oe_n, .host_pull_n, .irq_n,
    .auto_ack, .reset_line_in, .isr_read(host_read));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : step

  // bounded waits; running out of cycles ends the run as a mismatch
  task automatic wait_mode(input op_mode_type m, input int lim);
    n = 0;
    while (operating_mode !== m && n < lim) begin
      step(1);
      n++;
    end
    check("operating_mode", 8'(operating_mode), 8'(m));
    if (operating_mode !== m) stop_test();
  endtask : wait_mode

  task automatic wait_irq(input logic v, input int lim);
    n = 0;
    while (irq_n !== v && n < lim) begin
      step(1);
      n++;
    end
    check("irq_n", 8'(irq_n), 8'(v));
    if (irq_n !== v) stop_test();
  endtask : wait_irq

  task automatic write_mode(input logic [1:0] code);
    @(posedge core_clk) mode_control_register <= mode_select_type'(code);
    mode_write <= 1'b1;
    @(posedge core_clk) mode_write <= 1'b0;
    #1;
  endtask : write_mode

  task automatic go_mode(input logic [1:0] code, input op_mode_type m);
    write_mode(code);
    wait_mode(m, 3);
  endtask : go_mode

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    {rst_n, vdd_low, watchdog_fail, supply_undervoltage_flag, supply_overvoltage_flag} = '0;
    {watchdog_config_pin_grounded, mode_write, bench_read, wake_input_one, bus_wake} = '0;
    {pwm_gate_enable, pulse_width_input, cyclic_sense_enable, forced_wake_enable} = '0;
    {thermal_prewarning, wake_input_two} = '0;
    {chip_select_n, host_pull_n, auto_ack, high_side_setting} = 4'hf;
    low_side_setting = 2'h2;
    mode_control_register = '0;
    interrupt_mask_register = '0;
    fails = 0;
    n_compared = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    step(HOLD - 1);
    check("operating_mode", 8'(operating_mode), 8'(mode_reset));
    check("reset_line_oe_n", 8'(reset_line_oe_n), 8'h00);
    check("reset_line_out", 8'(reset_line_out), 8'h00);
    wait_mode(mode_normal_request, 4);
    check("reset_line_oe_n", 8'(reset_line_oe_n), 8'h01);
    check("reg_rx_tx", 8'({regulator_on, bus_rx_only, bus_tx_enable}), 8'h06);
    $display("test power_up done");
    wait_mode(mode_reset, NREQ + 4);
    check("timeout_len", 8'(n >= NREQ - 2), 8'h01);
    step(2);
    check("switches", 8'({low_side_outputs, high_side_output}), 8'h00);
    wait_mode(mode_normal_request, HOLD + 4);
    $display("test request_timeout done");
    go_mode(MODE_SEL_NORMAL, mode_normal);
    check("bus_tx_enable", 8'(bus_tx_enable), 8'h01);
    write_mode(2'h3);
    step(2);
    check("operating_mode", 8'(operating_mode), 8'(mode_normal));
    @(posedge core_clk) pwm_gate_enable <= 1'b1;
    step(2);
    check("switches", 8'({low_side_outputs, high_side_output}), 8'h00);
    @(posedge core_clk) pulse_width_input <= 1'b1;
    step(2);
    check("switches", 8'({low_side_outputs, high_side_output}), 8'h05);
    $display("test normal_entry done");
    @(posedge core_clk) supply_overvoltage_flag <= 1'b1;
    wait_irq(1'b0, 3);
    check("interrupt_source", 8'(interrupt_source), 8'h02);
    wait_irq(1'b1, 8);
    check("interrupt_source", 8'(interrupt_source), 8'h00);
    @(posedge core_clk) supply_overvoltage_flag <= 1'b0;
    interrupt_mask_register <= 6'h04;
    supply_undervoltage_flag <= 1'b1;
    step(3);
    check("irq_n", 8'(irq_n), 8'h01);
    check("interrupt_source", 8'(interrupt_source), 8'h04);
    @(posedge core_clk) supply_undervoltage_flag <= 1'b0;
    interrupt_mask_register <= 6'h00;
    @(posedge core_clk) thermal_prewarning <= 1'b1;
    wait_irq(1'b0, 3);
    check("interrupt_source", 8'(interrupt_source), 8'h05);
    wait_irq(1'b1, 8);
    $display("test interrupts done");
    go_mode(MODE_SEL_STOP, mode_stop);
    check("reg_on_limited", 8'({regulator_on, regulator_limited}), 8'h03);
    @(posedge core_clk) chip_select_n <= 1'b0;
    @(posedge core_clk) chip_select_n <= 1'b1;
    wait_mode(mode_normal_request, 3);
    check("irq_n", 8'(irq_n), 8'h01);
    go_mode(MODE_SEL_NORMAL, mode_normal);
    go_mode(MODE_SEL_STOP, mode_stop);
    @(posedge core_clk) bus_wake <= 1'b1;
    @(posedge core_clk) bus_wake <= 1'b0;
    wait_mode(mode_normal_request, 3);
    wait_irq(1'b0, 3);
    wait_irq(1'b1, 8);
    go_mode(MODE_SEL_NORMAL, mode_normal);
    go_mode(MODE_SEL_STOP, mode_stop);
    @(posedge core_clk) host_pull_n <= 1'b0;
    @(posedge core_clk) host_pull_n <= 1'b1;
    wait_mode(mode_normal_request, 4);
    check("irq_n", 8'(irq_n), 8'h01);
    @(posedge core_clk) forced_wake_enable <= 1'b1;
    go_mode(MODE_SEL_NORMAL, mode_normal);
    go_mode(MODE_SEL_STOP, mode_stop);
    wait_mode(mode_normal_request, LP + 4);
    wait_irq(1'b0, 3);
    check("timer_src", 8'(interrupt_source.timer_wake), 8'h01);
    wait_irq(1'b1, 8);
    @(posedge core_clk) forced_wake_enable <= 1'b0;
    $display("test stop_wake done");
    go_mode(MODE_SEL_NORMAL, mode_normal);
    go_mode(MODE_SEL_SLEEP, mode_sleep);
    check("regulator_on", 8'(regulator_on), 8'h00);
    @(posedge core_clk) chip_select_n <= 1'b0;
    @(posedge core_clk) chip_select_n <= 1'b1;
    step(3);
    check("operating_mode", 8'(operating_mode), 8'(mode_sleep));
    @(posedge core_clk) wake_input_one <= 1'b1;
    wait_mode(mode_reset, 4);
    check("irq_n", 8'(irq_n), 8'h01);
    check("wake_src", 8'(interrupt_source.wake_input), 8'h01);
    check("battery_fail", 8'(battery_fail_flag), 8'h00);
    wait_mode(mode_normal_request, HOLD + 4);
    @(posedge core_clk) supply_overvoltage_flag <= 1'b1;
    step(3);
    check("irq_n", 8'(irq_n), 8'h01);
    @(posedge core_clk) supply_overvoltage_flag <= 1'b0;
    bench_read <= 1'b1;
    @(posedge core_clk) bench_read <= 1'b0;
    step(2);
    check("wake_src", 8'(interrupt_source.wake_input), 8'h00);
    $display("test sleep_wake done");
    @(posedge core_clk) watchdog_config_pin_grounded <= 1'b1;
    wait_mode(mode_reset, NREQ + 4);
    seen = 1'b0;
    repeat (HOLD + 3) begin
      step(1);
      if (operating_mode === mode_normal_request) seen = 1'b1;
    end
    check("request_skipped", 8'(seen), 8'h00);
    check("operating_mode", 8'(operating_mode), 8'(mode_normal));
    @(posedge core_clk) watchdog_fail <= 1'b1;
    @(posedge core_clk) watchdog_fail <= 1'b0;
    wait_mode(mode_reset, 3);
    wait_mode(mode_normal, HOLD + 4);
    @(posedge core_clk) vdd_low <= 1'b1;
    wait_mode(mode_sleep, VLOW + 4);
    check("low_time", 8'(n >= VLOW - 2), 8'h01);
    @(posedge core_clk) vdd_low <= 1'b0;
    bus_wake <= 1'b1;
    @(posedge core_clk) bus_wake <= 1'b0;
    wait_mode(mode_reset, 4);
    @(posedge core_clk) vdd_low <= 1'b1;
    wait_mode(mode_sleep, 4);
    @(posedge core_clk) vdd_low <= 1'b0;
    cyclic_sense_enable <= 1'b1;
    wake_input_two <= 1'b1;
    step(4);
    check("operating_mode", 8'(operating_mode), 8'(mode_sleep));
    wait_mode(mode_reset, LP + 4);
    check("wake_src", 8'(interrupt_source.wake_input), 8'h01);
    $display("test faults done");
    stop_test();
  end
endmodule : sbc_operating_mode_controller_test
